//--- core/qbis_top.sv
// Baud prescaler, interrupt sharing and status port for four serial ports
// Function
// - One board strap picks divide 4, 2, 1
// - Divide-by-4 gives conventional rates up to 115.2K
// - Divide-by-2 doubles every rate, up to 230.4K
// - Divide-by-1 gives the top rate, 460.8K
// - Divide-by-1 line rate is four times nominal
// - Divide-by-1 rate is 460.8K over divisor
// - Divide-by-2 line rate is twice nominal
// - Divide-by-2 rate is 230.4K over divisor
// - Per-port mode: dedicated or shared interrupt line
// - One master port per line adds pull-down
// - Shared line without pull-down cannot interrupt
// - Read-only 8-bit pending summary at offset 7
`timescale 1ns/1ns
`include "qbis_defs.svh"
module qbis_top #(
    parameter int DIV_W = 16
) (
    input  wire logic                          clock_i,
    input  wire logic                          rst_i,
    input  wire logic                          ce_i,
    input  wire logic [1:0]                    clock_mode_strap_i,
    input  wire logic [2*`QBIS_NUM_PORTS-1:0]  port_irq_mode_strap_i,
    input  wire logic                          ext_pulldown_i,
    input  wire logic [`QBIS_NUM_PORTS-1:0]    uart_irq_i,
    input  wire logic [`QBIS_A_W-1:0]          avs_address_i,
    input  wire logic                          avs_read_i,
    input  wire logic                          avs_write_i,
    input  wire logic [31:0]                   avs_writedata_i,
    input  wire logic [3:0]                    avs_byteenable_i,
    output logic [31:0]                        avs_readdata_o,
    output logic                               avs_waitrequest_o,
    output logic                               baud_ref_tick_o,
    output logic [`QBIS_NUM_PORTS-1:0]         baud_tick_o,
    output logic [`QBIS_NUM_PORTS-1:0]         irq_line_o,
    output logic [`QBIS_NUM_PORTS-1:0]         irq_line_oe_o,
    output logic [`QBIS_NUM_PORTS-1:0]         irq_pulldown_o,
    output logic [`QBIS_ISP_W-1:0]             irq_pending_summary_port_o,
    output logic                               irq_o
);
    import qbis_pkg::*;
    localparam int NP = `QBIS_NUM_PORTS;

    // Strap decode, illegal code falls back to quarter rate
    function automatic qbis_rate_t to_rate(input logic [1:0] code);
        qbis_rate_t r;
        r = QBIS_QUARTER;
        unique case (code)
            2'b00:   r = QBIS_QUARTER;
            2'b01:   r = QBIS_HALF;
            2'b10:   r = QBIS_FULL;
            default: r = QBIS_QUARTER;
        endcase
        return r;
    endfunction

    // Prescaler terminal count per mode
    function automatic logic [`QBIS_PRE_W-1:0] last_cnt(input qbis_rate_t r);
        logic [`QBIS_PRE_W-1:0] v;
        v = `QBIS_LAST_QUART;
        unique case (r)
            QBIS_QUARTER: v = `QBIS_LAST_QUART;
            QBIS_HALF:    v = `QBIS_LAST_HALF;
            QBIS_FULL:    v = `QBIS_LAST_FULL;
            default:      v = `QBIS_LAST_QUART;
        endcase
        return v;
    endfunction

    // Byte-lane write merge
    function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return m;
    endfunction

    // ---------------- Strap synchronisers
    logic [1:0]        rate_s1_ff;
    logic [1:0]        rate_s2_ff;
    logic [2*NP-1:0]   mode_s1_ff;
    logic [2*NP-1:0]   mode_s2_ff;
    logic              pd_s1_ff;
    logic              pd_s2_ff;

    // Two flops on every strap pin
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rate_s1_ff <= '0;
            rate_s2_ff <= '0;
            mode_s1_ff <= '0;
            mode_s2_ff <= '0;
            pd_s1_ff   <= 1'b0;
            pd_s2_ff   <= 1'b0;
        end else if (ce_i) begin
            rate_s1_ff <= clock_mode_strap_i;
            rate_s2_ff <= rate_s1_ff;
            mode_s1_ff <= port_irq_mode_strap_i;
            mode_s2_ff <= mode_s1_ff;
            pd_s1_ff   <= ext_pulldown_i;
            pd_s2_ff   <= pd_s1_ff;
        end
    end

    // ---------------- Reference prescaler
    qbis_rate_t             rate_ff;
    logic [`QBIS_PRE_W-1:0] pre_cnt_ff;
    logic                   ref_tick_ff;
    wire qbis_rate_t        strap_rate = to_rate(rate_s2_ff);
    wire                    rate_chg   = strap_rate != rate_ff;
    wire                    pre_hit    = pre_cnt_ff >= last_cnt(rate_ff);
    wire [`QBIS_PRE_W-1:0]  nxt_pre    = pre_hit ? '0 : pre_cnt_ff + `QBIS_PRE_W'(1);

    // Mode register, counter and reference tick
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rate_ff     <= QBIS_QUARTER;
            pre_cnt_ff  <= '0;
            ref_tick_ff <= 1'b0;
        end else if (ce_i) begin
            rate_ff     <= strap_rate;
            pre_cnt_ff  <= nxt_pre;
            ref_tick_ff <= pre_hit;
        end
    end
    assign baud_ref_tick_o = ref_tick_ff;

    // ---------------- Avalon slave
    logic                   wait_ff;
    logic [31:0]            rdata_ff;
    logic [DIV_W-1:0]       div_ff [NP];
    logic [`QBIS_EVT_W-1:0] status_ff;
    logic [`QBIS_EVT_W-1:0] en_ff;
    logic [`QBIS_ISP_W-1:0] isp_ff;
    logic                   irq_ff;

    // Address decode
    wire       req     = avs_read_i || avs_write_i;
    wire       in_port = !avs_address_i[`QBIS_A_W-1];
    wire [1:0] pidx    = avs_address_i[4:3];
    wire [2:0] ofs     = avs_address_i[2:0];
    wire       wr_go   = avs_write_i && !wait_ff;
    wire       hit_div = in_port && ofs == `QBIS_OFS_DIV;
    wire       hit_isp = in_port && ofs == `QBIS_OFS_ISP;
    wire       hit_st  = avs_address_i == `QBIS_IDX_STAT;
    wire       hit_clr = avs_address_i == `QBIS_IDX_CLR;
    wire       hit_en  = avs_address_i == `QBIS_IDX_EN;
    wire       hit_md  = avs_address_i == `QBIS_IDX_MODE;

    // Read selection, unmapped words read zero
    wire [31:0] mode_word = 32'({pd_s2_ff, mode_s2_ff, rate_ff});
    wire [31:0] rd_mux    = hit_div ? 32'(div_ff[pidx]) :
                            hit_isp ? 32'(isp_ff) :
                            hit_st  ? 32'(status_ff) :
                            hit_en  ? 32'(en_ff) :
                            hit_md  ? mode_word : 32'h0000_0000;

    // Write data for the own registers
    wire [31:0]            en_new  = wr_merge(32'(en_ff), avs_writedata_i, avs_byteenable_i);
    wire [`QBIS_EVT_W-1:0] clr_new = avs_writedata_i[`QBIS_EVT_W-1:0];
    wire [`QBIS_EVT_W-1:0] clr_msk = (wr_go && hit_clr && avs_byteenable_i[0]) ?
                                     clr_new : '0;

    // Events: port request rising, strap mode change
    wire [`QBIS_EVT_W-1:0] evt = {rate_chg, uart_irq_i & ~isp_ff[NP-1:0]};
    wire [`QBIS_EVT_W-1:0] nxt_status = (status_ff & ~clr_msk) | evt;

    // One wait cycle, then answer
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wait_ff  <= 1'b1;
            rdata_ff <= '0;
        end else if (ce_i) begin
            wait_ff  <= !(req && wait_ff);
            if (avs_read_i && wait_ff) begin
                rdata_ff <= rd_mux;
            end
        end
    end
    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o    = rdata_ff;

    // Divisor registers, one per port window
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int p = 0; p < NP; p++) begin
                div_ff[p] <= DIV_W'(`QBIS_DIV_RST);
            end
        end else if (ce_i && wr_go && hit_div) begin
            div_ff[pidx] <= DIV_W'(wr_merge(32'(div_ff[pidx]), avs_writedata_i,
                                            avs_byteenable_i));
        end
    end

    // Status, enable, summary and interrupt output
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            status_ff <= '0;
            en_ff     <= '0;
            isp_ff    <= '0;
            irq_ff    <= 1'b0;
        end else if (ce_i) begin
            status_ff <= nxt_status;
            isp_ff    <= `QBIS_ISP_W'(uart_irq_i);
            irq_ff    <= |(status_ff & en_ff);
            if (wr_go && hit_en) begin
                en_ff <= en_new[`QBIS_EVT_W-1:0];
            end
        end
    end
    assign irq_pending_summary_port_o = isp_ff;
    assign irq_o                      = irq_ff;

    // ---------------- Per-port baud generators and line drivers
    logic [NP-1:0] master_vec;
    wire           pull_ok = pd_s2_ff || (|master_vec);

    for (genvar p = 0; p < NP; p++) begin : g_port
        wire qbis_irq_mode_t pmode = qbis_irq_mode_t'(mode_s2_ff[2*p +: 2]);
        assign master_vec[p] = pmode == QBIS_MASTER;

        qbis_baud_if #(.DIV_W(DIV_W)) bif ();
        assign bif.ref_tick  = ref_tick_ff;
        assign bif.divisor   = div_ff[p];
        assign baud_tick_o[p] = bif.baud_tick;

        qbis_baud_gen #(.DIV_W(DIV_W)) u_baud (
            .clock_i (clock_i),
            .rst_i   (rst_i),
            .ce_i    (ce_i),
            .bus     (bif.gen)
        );

        qbis_irq_drv u_irq (
            .clock_i    (clock_i),
            .rst_i      (rst_i),
            .ce_i       (ce_i),
            .mode_i     (pmode),
            .req_i      (uart_irq_i[p]),
            .pull_ok_i  (pull_ok),
            .line_o     (irq_line_o[p]),
            .line_oe_o  (irq_line_oe_o[p]),
            .pulldown_o (irq_pulldown_o[p])
        );
    end

    // ---------------- Checks
    logic [3:0] hold_ff;

    // Cycles since the reference mode last moved
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hold_ff <= '0;
        end else if (!ce_i || rate_chg) begin
            hold_ff <= '0;
        end else if (hold_ff != 4'hF) begin
            hold_ff <= hold_ff + 4'h1;
        end
    end
    wire settled = hold_ff >= `QBIS_HOLD_MIN;

    default clocking top_cb @(posedge clock_i); endclocking
    default disable iff (rst_i || !ce_i);

    property p_strap_follow;
        $stable(clock_mode_strap_i)[*4] |-> rate_ff == to_rate(clock_mode_strap_i);
    endproperty
    a_strap_follow: assert property (p_strap_follow) else $error("mode not taken");

    property p_quarter;
        ref_tick_ff && rate_ff == QBIS_QUARTER && settled |->
            $past(ref_tick_ff, 4) && !$past(ref_tick_ff, 3) &&
            !$past(ref_tick_ff, 2) && !$past(ref_tick_ff, 1);
    endproperty
    a_quarter: assert property (p_quarter) else $error("quarter spacing");

    property p_half;
        ref_tick_ff && rate_ff == QBIS_HALF && settled |->
            $past(ref_tick_ff, 2) && !$past(ref_tick_ff, 1);
    endproperty
    a_half: assert property (p_half) else $error("half spacing");

    property p_full;
        rate_ff == QBIS_FULL && settled |-> ref_tick_ff;
    endproperty
    a_full: assert property (p_full) else $error("full rate gap");

    sequence s_isp_req;
        avs_read_i && hit_isp && wait_ff;
    endsequence
    sequence s_isp_ans;
        !wait_ff && avs_readdata_o == 32'($past(isp_ff));
    endsequence
    property p_isp_read;
        s_isp_req |=> s_isp_ans;
    endproperty
    a_isp_read: assert property (p_isp_read) else $error("summary read");

    property p_isp_track;
        ce_i |=> irq_pending_summary_port_o == `QBIS_ISP_W'($past(uart_irq_i));
    endproperty
    a_isp_track: assert property (p_isp_track) else $error("summary stale");

    property p_set_wins;
        evt[0] |=> status_ff[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost");

    property p_irq_level;
        |(status_ff & en_ff) |=> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt low");

    // Waitrequest drops for exactly one cycle after a request is taken
    sequence s_bus_take;
        (avs_read_i || avs_write_i) && wait_ff;
    endsequence
    sequence s_bus_answer;
        !wait_ff ##1 wait_ff;
    endsequence
    property p_one_wait;
        s_bus_take |=> s_bus_answer;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state count");

    // A strap move is reported in the status word
    property p_rate_event;
        rate_chg |=> status_ff[`QBIS_EVT_W-1];
    endproperty
    a_rate_event: assert property (p_rate_event) else $error("mode event lost");

    // A cleared bit stays clear unless its event returns
    property p_clear;
        clr_msk[0] && !evt[0] |=> !status_ff[0];
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");
endmodule // qbis_top

//--- core/qbis_defs.svh
// Constants for the baud prescaler and interrupt share block
`ifndef QBIS_DEFS_SVH
`define QBIS_DEFS_SVH
// Port count, fixed by the register window layout
`define QBIS_NUM_PORTS  4
// Prescaler last-count per reference mode
`define QBIS_PRE_W       2
`define QBIS_LAST_QUART  2'h3
`define QBIS_LAST_HALF   2'h1
`define QBIS_LAST_FULL   2'h0
// Register word indices
`define QBIS_A_W         6
`define QBIS_OFS_DIV     3'h0
`define QBIS_OFS_ISP     3'h7
`define QBIS_IDX_STAT    6'h20
`define QBIS_IDX_CLR     6'h21
`define QBIS_IDX_EN      6'h22
`define QBIS_IDX_MODE    6'h23
// Reset values and field layout
`define QBIS_DIV_RST     16'h0001
`define QBIS_EVT_W       5
`define QBIS_ISP_W       8
`define QBIS_HOLD_MIN    4'h8
`endif

//--- core/qbis_pkg.sv
// Types shared by the baud prescaler and interrupt share block
package qbis_pkg;
    // Baud reference modes, selected by the board strap
    typedef enum logic [1:0] {
        QBIS_QUARTER = 2'b00,
        QBIS_HALF    = 2'b01,
        QBIS_FULL    = 2'b10
    } qbis_rate_t;
    // Per-port interrupt line modes
    typedef enum logic [1:0] {
        QBIS_NORMAL = 2'b00,
        QBIS_SHARED = 2'b01,
        QBIS_MASTER = 2'b10
    } qbis_irq_mode_t;
endpackage

//--- core/qbis_baud_if.sv
// Link between the prescaler and one port baud generator
`timescale 1ns/1ns
interface qbis_baud_if #(parameter int DIV_W = 16);
    logic             ref_tick;
    logic [DIV_W-1:0] divisor;
    logic             baud_tick;
    modport src (output ref_tick, output divisor, input baud_tick);
    modport gen (input ref_tick, input divisor, output baud_tick);
endinterface

//--- core/qbis_baud_gen.sv
// Per-port baud divider fed by the shared reference tick
`timescale 1ns/1ns
module qbis_baud_gen #(parameter int DIV_W = 16) (
    input  wire logic  clock_i,
    input  wire logic  rst_i,
    input  wire logic  ce_i,
    qbis_baud_if.gen   bus
);
    logic [DIV_W-1:0] cnt_ff;
    logic             tick_ff;
    wire              reload  = bus.ref_tick && (cnt_ff <= DIV_W'(1));
    wire [DIV_W-1:0]  nxt_cnt = reload ? bus.divisor :
                                bus.ref_tick ? cnt_ff - DIV_W'(1) : cnt_ff;

    // One line tick per divisor reference ticks
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (ce_i) begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= reload;
        end
    end
    assign bus.baud_tick = tick_ff;

    default clocking bg_cb @(posedge clock_i); endclocking
    default disable iff (rst_i || !ce_i);

    property p_reload_tick;
        bus.ref_tick && cnt_ff <= DIV_W'(1) |=> tick_ff && cnt_ff == $past(bus.divisor);
    endproperty
    a_reload_tick: assert property (p_reload_tick) else $error("reload missed");
    property p_scaled_rate;
        bus.ref_tick && cnt_ff > DIV_W'(1) |=> !tick_ff && cnt_ff == $past(cnt_ff) - DIV_W'(1);
    endproperty
    a_scaled_rate: assert property (p_scaled_rate) else $error("early tick");
    property p_no_ref_no_tick;
        !bus.ref_tick |=> !tick_ff;
    endproperty
    a_no_ref_no_tick: assert property (p_no_ref_no_tick) else $error("stray tick");
endmodule // qbis_baud_gen

//--- core/qbis_irq_drv.sv
// Interrupt line driver for one port: normal, shared or master-shared
`timescale 1ns/1ns
module qbis_irq_drv (
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    input  wire logic                    ce_i,
    input  wire qbis_pkg::qbis_irq_mode_t mode_i,
    input  wire logic                    req_i,
    input  wire logic                    pull_ok_i,
    output logic                         line_o,
    output logic                         line_oe_o,
    output logic                         pulldown_o
);
    import qbis_pkg::*;
    logic nxt_line;
    logic nxt_oe;
    logic nxt_pd;

    // Drive selection per mode
    always_comb begin
        unique case (mode_i)
            QBIS_NORMAL: begin
                nxt_line = req_i;
                nxt_oe   = 1'b1;
                nxt_pd   = 1'b0;
            end
            QBIS_SHARED: begin
                nxt_line = 1'b1;
                nxt_oe   = req_i && pull_ok_i;
                nxt_pd   = 1'b0;
            end
            QBIS_MASTER: begin
                nxt_line = 1'b1;
                nxt_oe   = req_i;
                nxt_pd   = 1'b1;
            end
            default: begin
                nxt_line = 1'b0;
                nxt_oe   = 1'b0;
                nxt_pd   = 1'b0;
            end
        endcase
    end

    // Registered pin drive
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            line_o     <= 1'b0;
            line_oe_o  <= 1'b0;
            pulldown_o <= 1'b0;
        end else if (ce_i) begin
            line_o     <= nxt_line;
            line_oe_o  <= nxt_oe;
            pulldown_o <= nxt_pd;
        end
    end

    default clocking id_cb @(posedge clock_i); endclocking
    default disable iff (rst_i || !ce_i);

    property p_normal;
        mode_i == QBIS_NORMAL |=> line_oe_o && line_o == $past(req_i);
    endproperty
    a_normal: assert property (p_normal) else $error("normal drive");
    property p_master;
        mode_i == QBIS_MASTER |=> pulldown_o && line_oe_o == $past(req_i);
    endproperty
    a_master: assert property (p_master) else $error("master pull");
    property p_mute;
        mode_i == QBIS_SHARED && !pull_ok_i |=> !line_oe_o && !pulldown_o;
    endproperty
    a_mute: assert property (p_mute) else $error("unpulled drive");
endmodule // qbis_irq_drv

//--- sim/qbis_host_model.sv
// Host side interrupt line model: wired line with optional pull-down
`timescale 1ns/1ns
module qbis_host_model (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] line_i,
    input  wire logic [3:0] line_oe_i,
    input  wire logic [3:0] pulldown_i,
    input  wire logic       ext_pulldown_i,
    output logic            host_irq_o
);
    logic float_ff;
    logic drv_hi;
    logic drv_lo;
    // Who holds the line: a driver, a pull-down, or nobody
    assign drv_hi = |(line_oe_i & line_i);
    assign drv_lo = |(line_oe_i & ~line_i) | (|pulldown_i) | ext_pulldown_i;
    // Floating line wanders so an undriven level never looks valid
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            float_ff <= 1'b0;
        end else begin
            float_ff <= ~float_ff;
        end
    end
    // Resolved level seen by the host
    assign host_irq_o = drv_hi ? 1'b1 : (drv_lo ? 1'b0 : float_ff);
endmodule // qbis_host_model

//--- sim/qbis_tb_top.sv
// Self-checking bench for the baud prescaler and interrupt share block
`timescale 1ns/1ns
`include "qbis_defs.svh"
module qbis_tb_top;
    import qbis_pkg::*;
    logic        clock_i;
    logic        rst_i;
    logic        ce;
    logic [1:0]  clk_strap;
    logic [7:0]  irq_strap;
    logic        ext_pd;
    logic [3:0]  uirq;
    logic [5:0]  addr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wait_rq;
    logic        ref_tick;
    logic [3:0]  btick;
    logic [3:0]  line;
    logic [3:0]  line_oe;
    logic [3:0]  pd;
    logic [7:0]  irq_pending_summary_port;
    logic        irq;
    logic        host_irq;
    int          fails;
    int          compares;
    int          cyc;
    logic [31:0] exp_q[$];
    // One master on the shared line at most: normal, master+shared, shared, shared, off
    logic [7:0]  strap_tab[5] = '{8'h00, 8'h56, 8'h55, 8'h55, 8'hFF};

    qbis_top dut_u (
        .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
        .clock_mode_strap_i(clk_strap), .port_irq_mode_strap_i(irq_strap),
        .ext_pulldown_i(ext_pd), .uart_irq_i(uirq), .avs_address_i(addr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq),
        .baud_ref_tick_o(ref_tick), .baud_tick_o(btick), .irq_line_o(line),
        .irq_line_oe_o(line_oe), .irq_pulldown_o(pd),
        .irq_pending_summary_port_o(irq_pending_summary_port), .irq_o(irq)
    );
    qbis_host_model host_u (
        .clock_i(clock_i), .rst_i(rst_i), .line_i(line), .line_oe_i(line_oe),
        .pulldown_i(pd), .ext_pulldown_i(ext_pd), .host_irq_o(host_irq)
    );

    // Clock at 4 ns period
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Avalon master: hold until waitrequest seen low, then release
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        rd_en <= ~w;
        wr_en <= w;
        @(posedge clock_i);
        while (wait_rq !== 1'b0) @(posedge clock_i);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    function automatic logic tick(input int sel);
        return (sel == 4) ? ref_tick : btick[sel];
    endfunction

    // Cycles between two successive ticks of one tick output
    task automatic period(input int sel, input int e);
        int n = 0;
        @(posedge clock_i);
        while (tick(sel) !== 1'b1 && n < 5000) begin
            @(posedge clock_i);
            n++;
        end
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (tick(sel) !== 1'b1 && n < 5000);
        check("tick period", 32'(n), 32'(e));
    endtask

    // Read result watcher takes the oldest expectation
    always @(posedge clock_i) begin
        if (rd_en === 1'b1 && wait_rq === 1'b0) begin
            check("readdata", rdata, exp_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        logic [3:0]  v;
        logic [31:0] d;
        int          e;
        logic [3:0]  exp4;
        fails = 0;
        compares = 0;
        cyc = 0;
        rst_i = 1'b1;
        ce = 1'b1;
        clk_strap = 2'h0;
        irq_strap = 8'h00;
        ext_pd = 1'b0;
        uirq = 4'h0;
        addr = 6'h00;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdata = 32'h0;
        void'($urandom(66));
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(6'h00, 32'h1);
        rd(`QBIS_IDX_STAT, 32'h0);
        // Pending summary mirrored at offset 7 of every port window
        for (int i = 0; i < 3; i++) begin
            v = 4'($urandom);
            uirq <= v;
            for (int p = 0; p < 4; p++) rd(6'(p * 8 + 7), {28'h0, v});
            check("summary", irq_pending_summary_port, {4'h0, v});
        end
        bus(1'b1, 6'h0F, 32'hFF);
        rd(6'h0F, {28'h0, v});
        bus(1'b1, 6'h30, 32'hFFFF);
        rd(6'h30, 32'h0);
        // Every strap code, a divisor per port, reference and line periods
        for (int m = 0; m < 4; m++) begin
            clk_strap <= 2'(m);
            d = 32'($urandom_range(4, 1));
            e = (m == 1) ? 2 : (m == 2) ? 1 : 4;
            bus(1'b1, 6'(m * 8), d);
            repeat (40) @(posedge clock_i);
            rd(6'(m * 8), d);
            rd(`QBIS_IDX_MODE, {21'h0, ext_pd, irq_strap, (m == 3) ? 2'b00 : 2'(m)});
            period(4, e);
            period(m, e * 32'(d));
        end
        // Interrupt modes with and without a pull-down present
        for (int k = 0; k < 5; k++) begin
            irq_strap <= strap_tab[k];
            ext_pd <= (k == 3);
            for (int j = 0; j < 2; j++) begin
                v = (j == 0) ? 4'($urandom) : 4'h0;
                uirq <= v;
                repeat (8) @(posedge clock_i);
                exp4 = (k == 0) ? 4'hF : (k == 2 || k == 4) ? 4'h0 : v;
                check("line_oe", line_oe, exp4);
                exp4 = (k == 0) ? v : (k == 4) ? 4'h0 : 4'hF;
                check("line", line, exp4);
                check("pulldown", pd, (k == 1) ? 4'h1 : 4'h0);
                if (k == 1 || k == 3) check("host_line", host_irq, |v);
            end
        end
        // Sticky status, masking and clearing of the interrupt
        uirq <= 4'h0;
        bus(1'b1, `QBIS_IDX_CLR, 32'h1F);
        bus(1'b1, `QBIS_IDX_EN, 32'h0);
        rd(`QBIS_IDX_STAT, 32'h0);
        // A strap move sets the mode event bit
        clk_strap <= 2'h1;
        repeat (6) @(posedge clock_i);
        rd(`QBIS_IDX_STAT, 32'h10);
        bus(1'b1, `QBIS_IDX_CLR, 32'h10);
        uirq <= 4'h2;
        repeat (4) @(posedge clock_i);
        check("irq masked", irq, 1'b0);
        rd(`QBIS_IDX_STAT, 32'h2);
        bus(1'b1, `QBIS_IDX_EN, 32'h2);
        repeat (3) @(posedge clock_i);
        check("irq", irq, 1'b1);
        bus(1'b1, `QBIS_IDX_CLR, 32'h2);
        repeat (3) @(posedge clock_i);
        check("irq cleared", irq, 1'b0);
        rd(`QBIS_IDX_STAT, 32'h0);
        rd(`QBIS_IDX_CLR, 32'h0);
        rd(`QBIS_IDX_EN, 32'h2);
        // Clock enable low freezes the summary register
        ce <= 1'b0;
        uirq <= 4'h5;
        repeat (4) @(posedge clock_i);
        check("frozen summary", irq_pending_summary_port, 8'h02);
        ce <= 1'b1;
        repeat (2) @(posedge clock_i);
        check("resumed summary", irq_pending_summary_port, 8'h05);
        repeat (2) @(posedge clock_i);
        test_done();
    end
endmodule // qbis_tb_top
